// *** hdl/asrr_top.sv ***
`timescale 1ns/1ps
module asrr_top
  import asrr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  // Register port
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [7:0]       rdata_out,
  // Power mode
  input  wire logic        standby_in,
  // Start triggers
  input  wire logic        pulse_timer_unit_trig_in,
  input  wire logic        timer8_trig_in,
  input  wire logic        ext_conv_trigger_pin_b_in,
  // Analog front end
  output logic [2:0]       analog_chan_out,
  output logic             sample_active_out,
  input  wire logic [9:0]  conv_data_in,
  // Interrupt request
  output logic             conv_end_irq_out
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic {
    ASRR_IDLE,
    ASRR_CONV
  } asrr_state_t;

  asrr_bus_req_t req;
  asrr_csr_t     csr;
  asrr_csr_t     next_csr;
  asrr_csr_t     wr_csr;
  asrr_state_t   state;
  asrr_state_t   next_state;
  logic [1:0]    trg_sel;
  logic [1:0]    next_trg_sel;
  logic [15:0]   halt_ctrl;
  logic [15:0]   next_halt_ctrl;
  logic [9:0]    result [0:3];
  logic [9:0]    next_result [0:3];
  logic [1:0]    low_hold;
  logic [1:0]    next_low_hold;
  logic [7:0]    rdata;
  logic [7:0]    next_rdata;
  logic          flag_armed;
  logic          next_flag_armed;
  logic [1:0]    slot;
  logic [1:0]    next_slot;
  logic          pin_fall;
  logic          timer_busy;
  logic          timer_done;
  logic          launch;
  logic          abort;
  logic          halted;
  logic          quiesce;
  logic          access_ok;
  logic          csr_wr;
  logic          ext_trig;

  assign req.addr  = addr_in;
  assign req.wdata = wdata_in;
  assign req.wr    = wr_in;
  assign req.rd    = rd_in;
  assign wr_csr    = asrr_csr_t'(req.wdata);

  // Result slot select from address bits 2:1 of a register byte pair
  function automatic logic [1:0] res_slot(input logic [15:0] addr);
    res_slot = addr[2:1];
  endfunction

  function automatic logic is_result(input logic [15:0] addr);
    is_result = (addr >= ADDR_RES_A_HI) && (addr <= ADDR_RES_D_LO);
  endfunction

  // ==========================================================================
  // Submodules
  // ==========================================================================
  asrr_trig_sync u_trig_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .pin_b_in   (ext_conv_trigger_pin_b_in),
    .fall_out   (pin_fall)
  );

  asrr_conv_timer u_conv_timer (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .start_in   (launch),
    .abort_in   (abort),
    .fast_in    (csr.conv_time_select),
    .busy_out   (timer_busy),
    .done_out   (timer_done)
  );

  // ==========================================================================
  // Mode and access qualifiers
  // ==========================================================================
  assign halted    = halt_ctrl[HALT_BIT];
  assign quiesce   = halted | standby_in;
  // Module halt register itself stays reachable, otherwise the block could never wake
  assign access_ok = ~quiesce;
  assign csr_wr    = req.wr && access_ok && (req.addr == ADDR_CSR);

  // ==========================================================================
  // Trigger selection
  // ==========================================================================
  always_comb begin
    ext_trig = 1'b0;
    unique case (asrr_trg_sel_t'(trg_sel))
      ASRR_TRG_NONE: ext_trig = 1'b0;
      ASRR_TRG_PTU:  ext_trig = pulse_timer_unit_trig_in;
      ASRR_TRG_TMR8: ext_trig = timer8_trig_in;
      ASRR_TRG_PIN:  ext_trig = pin_fall;
    endcase
  end

  // ==========================================================================
  // Sequencer and status
  // ==========================================================================
  always_comb begin
    next_state      = state;
    next_csr        = csr;
    next_slot       = slot;
    next_flag_armed = flag_armed;
    launch          = 1'b0;
    abort           = 1'b0;
    for (int i = 0; i < 4; i++) begin
      next_result[i] = result[i];
    end

    // Software write to the control/status byte
    if (csr_wr) begin
      next_csr.irq_enable       = wr_csr.irq_enable;
      next_csr.conv_start_bit   = wr_csr.conv_start_bit;
      next_csr.scan_mode        = wr_csr.scan_mode;
      next_csr.conv_time_select = wr_csr.conv_time_select;
      next_csr.chan_sel         = wr_csr.chan_sel;
      if (!wr_csr.conv_end_flag && flag_armed) begin
        next_csr.conv_end_flag = 1'b0;
      end
    end
    if (req.rd && access_ok && (req.addr == ADDR_CSR) && csr.conv_end_flag) begin
      next_flag_armed = 1'b1;
    end

    // Hardware triggers only act while stopped
    if (ext_trig && !csr.conv_start_bit && access_ok) begin
      next_csr.conv_start_bit = 1'b1;
    end

    unique case (state)
      ASRR_IDLE: begin
        if (csr.conv_start_bit && !quiesce) begin
          launch     = 1'b1;
          next_slot  = csr.scan_mode ? 2'h0 : csr.chan_sel[1:0];
          next_state = ASRR_CONV;
        end
      end
      ASRR_CONV: begin
        if (!csr.conv_start_bit || quiesce) begin
          abort      = 1'b1;
          next_state = ASRR_IDLE;
        end else if (timer_done) begin
          next_result[slot] = conv_data_in;
          if (!csr.scan_mode) begin
            next_csr.conv_start_bit = 1'b0;
            next_csr.conv_end_flag  = 1'b1;
            next_state              = ASRR_IDLE;
          end else begin
            launch = 1'b1;
            if (slot == csr.chan_sel[1:0]) begin
              next_csr.conv_end_flag = 1'b1;
              next_slot              = 2'h0;
            end else begin
              next_slot = slot + 2'h1;
            end
          end
        end
      end
    endcase

    if (!next_csr.conv_end_flag) begin
      next_flag_armed = 1'b0;
    end

    // Standby and halt wipe results and control state
    if (quiesce) begin
      next_state      = ASRR_IDLE;
      next_csr        = asrr_csr_t'(CSR_RESET);
      next_flag_armed = 1'b0;
      for (int i = 0; i < 4; i++) begin
        next_result[i] = RES_RESET;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state      <= ASRR_IDLE;
      csr        <= asrr_csr_t'(CSR_RESET);
      slot       <= 2'h0;
      flag_armed <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        result[i] <= RES_RESET;
      end
    end else begin
      state      <= next_state;
      csr        <= next_csr;
      slot       <= next_slot;
      flag_armed <= next_flag_armed;
      for (int i = 0; i < 4; i++) begin
        result[i] <= next_result[i];
      end
    end
  end

  // ==========================================================================
  // Trigger and halt control registers
  // ==========================================================================
  always_comb begin
    next_trg_sel   = trg_sel;
    next_halt_ctrl = halt_ctrl;
    if (req.wr && access_ok && (req.addr == ADDR_TRG)) begin
      next_trg_sel = req.wdata[7:6];
    end
    if (quiesce) begin
      next_trg_sel = TRG_SEL_RESET;
    end
    if (req.wr && (req.addr == ADDR_HALT_HI)) begin
      next_halt_ctrl[15:8] = req.wdata;
    end
    if (req.wr && (req.addr == ADDR_HALT_LO)) begin
      next_halt_ctrl[7:0] = req.wdata;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trg_sel   <= TRG_SEL_RESET;
      halt_ctrl <= HALT_RESET;
    end else begin
      trg_sel   <= next_trg_sel;
      halt_ctrl <= next_halt_ctrl;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    next_rdata    = 8'h00;
    next_low_hold = low_hold;
    if (quiesce) begin
      next_low_hold = 2'h0;
    end
    if (req.rd) begin
      if (req.addr == ADDR_HALT_HI) begin
        next_rdata = halt_ctrl[15:8];
      end else if (req.addr == ADDR_HALT_LO) begin
        next_rdata = halt_ctrl[7:0];
      end else if (!access_ok) begin
        next_rdata = 8'h00;
      end else if (is_result(req.addr)) begin
        if (!req.addr[0]) begin
          next_rdata    = result[res_slot(req.addr)][9:RES_HI_LSB];
          next_low_hold = result[res_slot(req.addr)][1:0];
        end else begin
          // Low byte is stale unless the high byte of the same register came first
          next_rdata = {low_hold, RES_LOW_PAD};
        end
      end else if (req.addr == ADDR_CSR) begin
        next_rdata = csr;
      end else if (req.addr == ADDR_TRG) begin
        next_rdata = {trg_sel, TRG_RSVD_READ};
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata    <= 8'h00;
      low_hold <= 2'h0;
    end else begin
      rdata    <= next_rdata;
      low_hold <= next_low_hold;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rdata_out         = rdata;
  assign analog_chan_out   = {csr.chan_sel[2], slot};
  assign sample_active_out = timer_busy;
  assign conv_end_irq_out  = csr.conv_end_flag & csr.irq_enable;

endmodule

// *** shared/asrr_pkg.sv ***
package asrr_pkg;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [15:0] ADDR_HALT_HI  = 16'hFF3C;
  localparam logic [15:0] ADDR_HALT_LO  = 16'hFF3D;
  localparam logic [15:0] ADDR_RES_A_HI = 16'hFF90;
  localparam logic [15:0] ADDR_RES_A_LO = 16'hFF91;
  localparam logic [15:0] ADDR_RES_B_HI = 16'hFF92;
  localparam logic [15:0] ADDR_RES_B_LO = 16'hFF93;
  localparam logic [15:0] ADDR_RES_C_HI = 16'hFF94;
  localparam logic [15:0] ADDR_RES_C_LO = 16'hFF95;
  localparam logic [15:0] ADDR_RES_D_HI = 16'hFF96;
  localparam logic [15:0] ADDR_RES_D_LO = 16'hFF97;
  localparam logic [15:0] ADDR_CSR      = 16'hFF98;
  localparam logic [15:0] ADDR_TRG      = 16'hFF99;

  // ==========================================================================
  // Reset values and field positions
  // ==========================================================================
  localparam logic [15:0] HALT_RESET    = 16'h3FFF;
  localparam int          HALT_BIT      = 9;
  localparam logic [7:0]  CSR_RESET     = 8'h00;
  localparam logic [1:0]  TRG_SEL_RESET = 2'h0;
  localparam logic [5:0]  TRG_RSVD_READ = 6'h3F;
  localparam logic [9:0]  RES_RESET     = 10'h000;
  localparam logic [5:0]  RES_LOW_PAD   = 6'h00;
  localparam int          RES_HI_LSB    = 2;
  localparam int          CSR_END_BIT   = 7;
  localparam int          CSR_START_BIT = 5;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          REF_STATE_NS     = 50;
  localparam int          MIN_CONV_TIME_NS = 6700;
  localparam int          STATE_CYCLES     = (REF_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          MIN_CONV_CYCLES  = (MIN_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0]  CONV_STATES_SLOW = 9'h10A;
  localparam logic [8:0]  CONV_STATES_FAST = 9'h086;
  localparam logic [1:0]  STATE_DIV_LAST   = 2'(STATE_CYCLES - 1);

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    ASRR_TRG_NONE = 2'h0,
    ASRR_TRG_PTU  = 2'h1,
    ASRR_TRG_TMR8 = 2'h2,
    ASRR_TRG_PIN  = 2'h3
  } asrr_trg_sel_t;

  typedef struct packed {
    logic       conv_end_flag;
    logic       irq_enable;
    logic       conv_start_bit;
    logic       scan_mode;
    logic       conv_time_select;
    logic [2:0] chan_sel;
  } asrr_csr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } asrr_bus_req_t;

endpackage

// *** hdl/asrr_trig_sync.sv ***
`timescale 1ns/1ps
module asrr_trig_sync
  import asrr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  // Pin side
  input  wire logic pin_b_in,
  // Logic side
  output logic      fall_out
);

  // ==========================================================================
  // Synchroniser and falling edge
  // ==========================================================================
  logic meta;
  logic stable;
  logic prev;
  logic fall;
  logic next_fall;

  always_comb begin
    next_fall = prev & ~stable;
  end

  // Idle level of the active-low pin is high
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta   <= 1'b1;
      stable <= 1'b1;
      prev   <= 1'b1;
      fall   <= 1'b0;
    end else begin
      meta   <= pin_b_in;
      stable <= meta;
      prev   <= stable;
      fall   <= next_fall;
    end
  end

  assign fall_out = fall;

endmodule

// *** hdl/asrr_conv_timer.sv ***
`timescale 1ns/1ps
module asrr_conv_timer
  import asrr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  // Control
  input  wire logic start_in,
  input  wire logic abort_in,
  input  wire logic fast_in,
  // Status
  output logic      busy_out,
  output logic      done_out
);

  // ==========================================================================
  // State counter
  // ==========================================================================
  logic       busy;
  logic       done;
  logic [1:0] div;
  logic [8:0] states;
  logic [8:0] target;
  logic       next_busy;
  logic       next_done;
  logic [1:0] next_div;
  logic [8:0] next_states;
  logic [8:0] next_target;

  // One state is one reference period, so the fast setting never beats the minimum time
  always_comb begin
    next_busy   = busy;
    next_done   = 1'b0;
    next_div    = div;
    next_states = states;
    next_target = target;
    if (abort_in) begin
      next_busy = 1'b0;
    end else if (start_in) begin
      next_busy   = 1'b1;
      next_div    = 2'h0;
      next_states = 9'h000;
      next_target = fast_in ? CONV_STATES_FAST : CONV_STATES_SLOW;
    end else if (busy) begin
      if (div == STATE_DIV_LAST) begin
        next_div    = 2'h0;
        next_states = states + 9'h001;
        if (states == target - 9'h001) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end
      end else begin
        next_div = div + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy   <= 1'b0;
      done   <= 1'b0;
      div    <= 2'h0;
      states <= 9'h000;
      target <= CONV_STATES_SLOW;
    end else begin
      busy   <= next_busy;
      done   <= next_done;
      div    <= next_div;
      states <= next_states;
      target <= next_target;
    end
  end

  assign busy_out = busy;
  assign done_out = done;

endmodule

// *** verif/asrr_top_properties.sv ***
`timescale 1ns/1ps
module asrr_top_properties
  import asrr_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  // Register port
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  // Mode and triggers
  input wire logic        standby_in,
  input wire logic        pulse_timer_unit_trig_in,
  input wire logic        timer8_trig_in,
  input wire logic        ext_conv_trigger_pin_b_in,
  // Converter side
  input wire logic [2:0]  analog_chan_out,
  input wire logic        sample_active_out,
  input wire logic [9:0]  conv_data_in,
  input wire logic        conv_end_irq_out
);
  // ==========================================================================
  // Shadow state
  // ==========================================================================
  // Slack of a few cycles for the launch edge
  localparam logic [9:0] MIN_RUN = 10'(MIN_CONV_CYCLES - 4);
  logic       halted, next_halted;
  logic [1:0] trg_sel, next_trg_sel;
  logic [9:0] run_cnt, next_run_cnt;
  logic       cut, next_cut;

  always_comb begin
    next_halted  = halted;
    next_trg_sel = trg_sel;
    if (wr_in && addr_in == ADDR_HALT_HI) begin
      next_halted = wdata_in[1];
    end
    // Cleared when halted too, so a stale selection never arms a check
    if (halted || standby_in) begin
      next_trg_sel = 2'h0;
    end else if (wr_in && addr_in == ADDR_TRG) begin
      next_trg_sel = wdata_in[7:6];
    end
    next_run_cnt = !sample_active_out ? 10'h000 : (run_cnt == 10'h3FF) ? run_cnt : run_cnt + 10'h001;
    next_cut     = sample_active_out & (cut | wr_in | standby_in);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      halted  <= 1'b1;
      trg_sel <= 2'h0;
      run_cnt <= 10'h000;
      cut     <= 1'b0;
    end else begin
      halted  <= next_halted;
      trg_sel <= next_trg_sel;
      run_cnt <= next_run_cnt;
      cut     <= next_cut;
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_idle;
    !sample_active_out && !halted && !standby_in;
  endsequence
  sequence s_sw_start;
    wr_in && addr_in == ADDR_CSR && wdata_in[CSR_START_BIT] && !halted && !standby_in;
  endsequence
  sequence s_tmr_start;
    !wr_in && ((pulse_timer_unit_trig_in && trg_sel == 2'h1) || (timer8_trig_in && trg_sel == 2'h2));
  endsequence
  sequence s_launch;
    ##[1:3] sample_active_out;
  endsequence

  a_read_idle_zero: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00) else $error("read data not zero outside a read answer");
  a_low_pad_zero: assert property (
    $past(rd_in) && $past(addr_in[15:3]) == ADDR_RES_A_LO[15:3] && $past(addr_in[0])
    |-> rdata_out[5:0] == RES_LOW_PAD) else $error("low result byte padding not zero");
  a_halt_read_zero: assert property (
    $past(rd_in) && ($past(halted) || $past(standby_in)) && $past(addr_in[15:1]) != ADDR_HALT_HI[15:1]
    |-> rdata_out == 8'h00) else $error("register readable while halted");
  a_halt_bit_read: assert property (
    $past(rd_in) && $past(addr_in) == ADDR_HALT_HI |-> rdata_out[1] == $past(halted))
    else $error("halt bit reads wrong");
  a_trg_rsvd_ones: assert property (
    $past(rd_in) && $past(addr_in) == ADDR_TRG && !$past(halted) && !$past(standby_in)
    |-> rdata_out[5:0] == TRG_RSVD_READ) else $error("trigger reserved bits not ones");
  a_standby_quiet: assert property (
    $past(standby_in) && standby_in |-> !sample_active_out && !conv_end_irq_out)
    else $error("activity during standby");
  a_halt_quiet: assert property (
    $past(halted) && halted |-> !sample_active_out && !conv_end_irq_out) else $error("activity while halted");
  a_sw_start_launch: assert property (
    s_sw_start |-> s_launch) else $error("software start did not launch");
  a_tmr_start_launch: assert property (
    s_idle and s_tmr_start |-> s_launch) else $error("timer start did not launch");
  a_pin_start_launch: assert property (
    $fell(ext_conv_trigger_pin_b_in) && trg_sel == 2'h3 && !sample_active_out && !halted && !standby_in
    |-> ##[3:8] sample_active_out) else $error("pin start did not launch");
  a_conv_min_len: assert property (
    $fell(sample_active_out) && !cut |-> run_cnt >= MIN_RUN) else $error("conversion shorter than minimum");
endmodule

bind asrr_top asrr_top_properties u_asrr_top_properties (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .standby_in(standby_in),
  .pulse_timer_unit_trig_in(pulse_timer_unit_trig_in), .timer8_trig_in(timer8_trig_in),
  .ext_conv_trigger_pin_b_in(ext_conv_trigger_pin_b_in), .analog_chan_out(analog_chan_out),
  .sample_active_out(sample_active_out), .conv_data_in(conv_data_in), .conv_end_irq_out(conv_end_irq_out)
);

// *** verif/asrr_afe_model.sv ***
`timescale 1ns/1ps
module asrr_afe_model
  import asrr_pkg::*;
(
  // Converter side
  input  wire logic [2:0] analog_chan_in,
  input  wire logic [9:0] level_in,
  // Result
  output logic [9:0]      conv_data_out
);
  // Each input XORs in its own bit pattern so a wrong channel mux shows up
  assign conv_data_out = level_in ^ {analog_chan_in, analog_chan_in, analog_chan_in, analog_chan_in[0]};
endmodule

// *** verif/adc_sequencer_result_regs_tb_top.sv ***
`timescale 1ns/1ps
module adc_sequencer_result_regs_tb_top;
  import asrr_pkg::*;
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (got), (exp)); end end

  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        standby_in = 1'b0;
  logic        pulse_timer_unit_trig_in = 1'b0;
  logic        timer8_trig_in = 1'b0;
  logic        ext_conv_trigger_pin_b_in = 1'b1;
  logic [9:0]  level = 10'h000;
  logic [7:0]  rdata_out;
  logic [2:0]  analog_chan_out;
  logic        sample_active_out;
  logic [9:0]  conv_data_in;
  logic        conv_end_irq_out;
  logic [7:0]  rd_val;
  logic [31:0] seed = 32'h521C;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc;
  int          exp_res [4] = '{0, 0, 0, 0};
  int          scan_q [$];

  always #12.5 clk_sys_in = ~clk_sys_in;

  asrr_top u_asrr_top (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .standby_in(standby_in),
    .pulse_timer_unit_trig_in(pulse_timer_unit_trig_in), .timer8_trig_in(timer8_trig_in),
    .ext_conv_trigger_pin_b_in(ext_conv_trigger_pin_b_in), .analog_chan_out(analog_chan_out),
    .sample_active_out(sample_active_out), .conv_data_in(conv_data_in), .conv_end_irq_out(conv_end_irq_out)
  );
  asrr_afe_model u_asrr_afe_model (
    .analog_chan_in(analog_chan_out), .level_in(level), .conv_data_out(conv_data_in)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic int expect_for(input int ch);
    return int'(level) ^ ((ch << 7) | (ch << 4) | (ch << 1) | (ch & 1));
  endfunction

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in   <= 1'b0;
    #1 rd_val = rdata_out;
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    rd_reg(a);
    `CHK(rd_val, e)
  endtask

  // High byte always before low byte, as software must
  task automatic chk_res();
    for (int k = 0; k < 4; k++) begin
      chk_rd(16'(ADDR_RES_A_HI + 2 * k), 8'(exp_res[k] >> 2));
      chk_rd(16'(ADDR_RES_A_HI + 2 * k + 1), {2'(exp_res[k]), RES_LOW_PAD});
    end
  endtask

  task automatic wait_csr(input logic [7:0] mask, input logic [7:0] want);
    cyc = 0;
    rd_reg(ADDR_CSR);
    while ((rd_val & mask) !== want) begin
      cyc += 2;
      if (cyc > 4000) begin
        n_mismatch++;
        $display("BAD t=%0t status wait ran out", $time);
        print_verdict();
      end
      rd_reg(ADDR_CSR);
    end
  endtask

  // how: 0 software, 1 first timer, 2 second timer, 3 pin
  task automatic convert(input int ch, input int how, input logic fast, input logic ie);
    logic [7:0] mode;
    mode = {1'b0, ie, 2'b00, fast, 3'(ch)};
    seed = xorshift(seed);
    level <= seed[9:0];
    if (how == 0) begin
      wr_reg(ADDR_CSR, mode | 8'h20);
    end else begin
      wr_reg(ADDR_CSR, mode);
      wr_reg(ADDR_TRG, {2'(how), 6'h00});
      pulse_timer_unit_trig_in  <= (how == 1);
      timer8_trig_in            <= (how == 2);
      ext_conv_trigger_pin_b_in <= (how != 3);
      @(posedge clk_sys_in);
      pulse_timer_unit_trig_in <= 1'b0;
      timer8_trig_in           <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      ext_conv_trigger_pin_b_in <= 1'b1;
    end
    wait_csr(8'h20, 8'h00);
    exp_res[ch % 4] = expect_for(ch);
    if (how == 0) begin
      `CHK(cyc >= MIN_CONV_CYCLES - 2, 1'b1)
      `CHK(cyc <= (fast ? 268 : 532) + 8, 1'b1)
    end
    chk_rd(ADDR_CSR, mode | 8'h80);
    `CHK(conv_end_irq_out, ie)
    chk_res();
    wr_reg(ADDR_CSR, mode);
    chk_rd(ADDR_CSR, mode);
    `CHK(conv_end_irq_out, 1'b0)
    wr_reg(ADDR_CSR, mode | 8'h80);
    chk_rd(ADDR_CSR, mode);
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    chk_rd(ADDR_HALT_HI, HALT_RESET[15:8]);
    chk_rd(ADDR_HALT_LO, HALT_RESET[7:0]);
    wr_reg(ADDR_CSR, 8'h20);
    chk_rd(ADDR_CSR, 8'h00);
    `CHK(sample_active_out, 1'b0)
    wr_reg(ADDR_HALT_HI, 8'h3D);
    chk_rd(ADDR_TRG, {TRG_SEL_RESET, TRG_RSVD_READ});
    chk_rd(ADDR_CSR, CSR_RESET);
    wr_reg(ADDR_RES_A_HI, 8'hA5);
    chk_rd(16'hFF9A, 8'h00);
    chk_res();
    $display("test reset done");
    for (int ch = 0; ch < 8; ch++) begin
      convert(ch, 0, 1'(ch != 3), 1'(ch % 2));
    end
    $display("test single done");
    for (int how = 1; how < 4; how++) begin
      convert(how + 3, how, 1'b1, 1'b1);
    end
    wr_reg(ADDR_TRG, 8'h00);
    wr_reg(ADDR_CSR, 8'h08);
    pulse_timer_unit_trig_in  <= 1'b1;
    timer8_trig_in            <= 1'b1;
    ext_conv_trigger_pin_b_in <= 1'b0;
    @(posedge clk_sys_in);
    pulse_timer_unit_trig_in <= 1'b0;
    timer8_trig_in           <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    ext_conv_trigger_pin_b_in <= 1'b1;
    chk_rd(ADDR_CSR, 8'h08);
    $display("test triggers done");
    scan_q = '{4, 5, 6};
    seed = xorshift(seed);
    level <= seed[9:0];
    wr_reg(ADDR_CSR, 8'h3E);
    wait_csr(8'h80, 8'h80);
    foreach (scan_q[i]) exp_res[scan_q[i] % 4] = expect_for(scan_q[i]);
    chk_res();
    wr_reg(ADDR_CSR, 8'h3E);
    chk_rd(ADDR_CSR, 8'h3E);
    wait_csr(8'h80, 8'h80);
    `CHK(cyc >= 3 * MIN_CONV_CYCLES - 20, 1'b1)
    wr_reg(ADDR_CSR, 8'h1E);
    $display("test scan done");
    wr_reg(ADDR_HALT_HI, 8'h3F);
    chk_rd(ADDR_RES_A_HI, 8'h00);
    wr_reg(ADDR_HALT_HI, 8'h3D);
    exp_res = '{0, 0, 0, 0};
    chk_res();
    convert(1, 0, 1'b1, 1'b0);
    // Non-reset trigger selection so the standby clear is visible
    wr_reg(ADDR_TRG, 8'h40);
    standby_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    standby_in <= 1'b0;
    exp_res = '{0, 0, 0, 0};
    chk_res();
    chk_rd(ADDR_CSR, CSR_RESET);
    chk_rd(ADDR_TRG, {TRG_SEL_RESET, TRG_RSVD_READ});
    $display("test clear done");
    print_verdict();
  end
endmodule
